// File: common/io_image_cfg.svh
// io image mapper constants: layout of the process data area
// assumes inclusion by bare name from the package and design files
`ifndef IO_IMAGE_CFG_SVH
`define IO_IMAGE_CFG_SVH
`define IMG_BYTES_FULL 32
`define IMG_BYTES_SHORT 16
`define IMG_B_BASE 16
`define IMG_STATUS_BYTE 0
`define IMG_NIB_HI_LSB 4
`define IMG_NIB_LO_LSB 0
`define IMG_ADDR_W 16
`define IMG_START_RST 16'h0000
`define IMG_MAX_ADDR 31
`endif

// File: common/io_image_pkg.sv
// io image mapper types: sort modes and slave bank selector
// assumes the constants header sits next to it
`include "io_image_cfg.svh"
package io_image_pkg;
	typedef enum logic [1:0] {
		slot_order_sort = 2'h1,
		address_paired_sort = 2'h2
	} sort_mode_t;
	typedef enum logic {
		bank_a = 1'h0,
		bank_b = 1'h1
	} bank_t;
	typedef struct packed {
		logic valid;
		bank_t bank;
		logic [4:0] addr;
	} nib_src_t;
endpackage : io_image_pkg

// File: hw/nibble_locator.sv
// nibble locator: which slave owns a nibble of the data area
// assumes a pure combinational use by the mapper
`timescale 1ns/1ps
`include "io_image_cfg.svh"
module nibble_locator
	import io_image_pkg::*;
(
	input wire sort_mode_t mode,
	input wire logic [4:0] byte_idx,
	input wire logic hi,
	input wire logic area_short,
	output io_image_pkg::nib_src_t src
);
	always_comb begin
		src = '0;
		if (mode == address_paired_sort) begin
			// byte k serves address k, a low, b high
			if (byte_idx != 5'h00) begin
				src.valid = 1'b1;
				src.bank = hi ? bank_b : bank_a;
				src.addr = byte_idx;
			end
		end else if (mode == slot_order_sort) begin
			if (byte_idx < 5'(`IMG_B_BASE)) begin
				// even address high, odd low
				src.valid = !(byte_idx == 5'h00 && hi);
				src.bank = bank_a;
				src.addr = {byte_idx[3:0], !hi};
			end else if (!area_short) begin
				src.valid = !(byte_idx == 5'(`IMG_B_BASE) && hi);
				src.bank = bank_b;
				src.addr = {byte_idx[3:0], !hi};
			end
		end
	end
endmodule : nibble_locator

// File: hw/io_image_mapper.sv
// io image mapper: slave nibbles to and from a byte-wide process image
// assumes slave tables and byte port are on clk; status nibble from master
`timescale 1ns/1ps
`include "io_image_cfg.svh"
module io_image_mapper
	import io_image_pkg::*;
#(
	parameter int ADDR_W = `IMG_ADDR_W
)(
	input wire logic clk,
	input wire logic arst_n,
	input wire sort_mode_t mode,
	input wire logic area_short,
	input wire logic [ADDR_W-1:0] start_addr,
	input wire logic [3:0] status_nib,
	input wire logic [3:0] in_a [32],
	input wire logic [3:0] in_b [32],
	input wire logic [31:0] cfg_a,
	input wire logic [31:0] cfg_b,
	input wire logic rd_en,
	input wire logic [ADDR_W-1:0] rd_addr,
	output logic [7:0] rd_data,
	output logic rd_valid,
	input wire logic wr_en,
	input wire logic [ADDR_W-1:0] wr_addr,
	input wire logic [7:0] wr_data,
	output logic [3:0] out_a [32],
	output logic [3:0] out_b [32]
);
	logic [ADDR_W-1:0] rd_off, wr_off;
	logic rd_in, wr_in;
	nib_src_t rs_lo, rs_hi, ws_lo, ws_hi;
	logic [7:0] rd_nxt;

	function automatic logic in_area(input logic [ADDR_W-1:0] off, input logic short_area);
		in_area = off < (short_area ? ADDR_W'(`IMG_BYTES_SHORT) : ADDR_W'(`IMG_BYTES_FULL));
	endfunction : in_area

	function automatic logic [3:0] pick(input nib_src_t s, input logic [3:0] a [32],
		input logic [3:0] b [32], input logic [31:0] ca, input logic [31:0] cb);
		pick = 4'h0;
		if (s.valid) begin
			if (s.bank == bank_b) begin
				pick = cb[s.addr] ? b[s.addr] : 4'h0;
			end else begin
				pick = ca[s.addr] ? a[s.addr] : 4'h0;
			end
		end
	endfunction : pick

	assign rd_off = rd_addr - start_addr;
	assign wr_off = wr_addr - start_addr;
	assign rd_in = in_area(rd_off, area_short);
	assign wr_in = in_area(wr_off, area_short);

	nibble_locator u_rd_lo (.mode(mode), .byte_idx(rd_off[4:0]), .hi(1'b0),
		.area_short(area_short), .src(rs_lo));
	nibble_locator u_rd_hi (.mode(mode), .byte_idx(rd_off[4:0]), .hi(1'b1),
		.area_short(area_short), .src(rs_hi));
	nibble_locator u_wr_lo (.mode(mode), .byte_idx(wr_off[4:0]), .hi(1'b0),
		.area_short(area_short), .src(ws_lo));
	nibble_locator u_wr_hi (.mode(mode), .byte_idx(wr_off[4:0]), .hi(1'b1),
		.area_short(area_short), .src(ws_hi));

	always_comb begin
		rd_nxt = 8'h00;
		if (rd_in) begin
			rd_nxt[3:0] = pick(rs_lo, in_a, in_b, cfg_a, cfg_b);
			rd_nxt[7:4] = pick(rs_hi, in_a, in_b, cfg_a, cfg_b);
			if (rd_off == ADDR_W'(`IMG_STATUS_BYTE)) begin
				rd_nxt[7:4] = status_nib;
			end
		end
	end

	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			rd_data <= 8'h00;
			rd_valid <= 1'b0;
		end else begin
			rd_valid <= rd_en;
			if (rd_en) begin
				rd_data <= rd_nxt;
			end
		end
	end

	// output nibbles, byte 0 high never has a source so it is dropped
	always_ff @(posedge clk or negedge arst_n) begin
		if (!arst_n) begin
			for (int i = 0; i < 32; i++) begin
				out_a[i] <= 4'h0;
				out_b[i] <= 4'h0;
			end
		end else if (wr_en && wr_in) begin
			if (ws_lo.valid) begin
				if (ws_lo.bank == bank_b) begin
					out_b[ws_lo.addr] <= wr_data[3:0];
				end else begin
					out_a[ws_lo.addr] <= wr_data[3:0];
				end
			end
			if (ws_hi.valid && wr_off != ADDR_W'(`IMG_STATUS_BYTE)) begin
				if (ws_hi.bank == bank_b) begin
					out_b[ws_hi.addr] <= wr_data[7:4];
				end else begin
					out_a[ws_hi.addr] <= wr_data[7:4];
				end
			end
		end
	end

	// checks
	property p_rd_status;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && rd_off == '0) |=> rd_data[7:4] == $past(status_nib);
	endproperty
	a_rd_status: assert property (p_rd_status) else $error("status nibble wrong");

	property p_rd_valid;
		@(posedge clk) disable iff (!arst_n) rd_en |=> rd_valid;
	endproperty
	a_rd_valid: assert property (p_rd_valid) else $error("read not answered");

	property p_out_of_area;
		@(posedge clk) disable iff (!arst_n) (rd_en && !rd_in) |=> rd_data == 8'h00;
	endproperty
	a_out_of_area: assert property (p_out_of_area) else $error("outside area nonzero");

	property p_short_no_b;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && area_short && rd_off == ADDR_W'(`IMG_B_BASE)) |=> rd_data == 8'h00;
	endproperty
	a_short_no_b: assert property (p_short_no_b) else $error("short area shows b data");

	property p_slot_b_res;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && !area_short && mode == slot_order_sort && rd_off == ADDR_W'(`IMG_B_BASE))
		|=> rd_data[7:4] == 4'h0;
	endproperty
	a_slot_b_res: assert property (p_slot_b_res) else $error("byte 16 high not zero");

	property p_pair_res;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == address_paired_sort && rd_off == '0) |=> rd_data[3:0] == 4'h0;
	endproperty
	a_pair_res: assert property (p_pair_res) else $error("byte 0 low not zero");

	property p_slot_1a;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == slot_order_sort && rd_off == '0)
		|=> rd_data[3:0] == $past(cfg_a[1] ? in_a[1] : 4'h0);
	endproperty
	a_slot_1a: assert property (p_slot_1a) else $error("slave 1a misplaced");

	property p_pair_b;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == address_paired_sort && rd_in && rd_off != '0)
		|=> rd_data[7:4] == $past(cfg_b[rd_off[4:0]] ? in_b[rd_off[4:0]] : 4'h0);
	endproperty
	a_pair_b: assert property (p_pair_b) else $error("paired b misplaced");

	property p_slot_even;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == slot_order_sort && rd_off == 16'h000F)
		|=> rd_data[7:4] == $past(cfg_a[30] ? in_a[30] : 4'h0);
	endproperty
	a_slot_even: assert property (p_slot_even) else $error("slave 30a misplaced");

	property p_slot_odd;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == slot_order_sort && rd_off == ADDR_W'(1))
		|=> rd_data[3:0] == $past(cfg_a[3] ? in_a[3] : 4'h0);
	endproperty
	a_slot_odd: assert property (p_slot_odd) else $error("slave 3a misplaced");

	property p_slot_b31;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == slot_order_sort && !area_short && rd_off == ADDR_W'(`IMG_MAX_ADDR))
		|=> rd_data == $past({cfg_b[30] ? in_b[30] : 4'h0, cfg_b[31] ? in_b[31] : 4'h0});
	endproperty
	a_slot_b31: assert property (p_slot_b31) else $error("slaves 30b 31b misplaced");

	// unconfigured odd a slave in the low half reads zero
	property p_unconf_a;
		@(posedge clk) disable iff (!arst_n)
		(rd_en && mode == slot_order_sort && rd_off < ADDR_W'(`IMG_B_BASE)
			&& !cfg_a[{rd_off[3:0], 1'b1}])
		|=> rd_data[3:0] == 4'h0;
	endproperty
	a_unconf_a: assert property (p_unconf_a) else $error("unconfigured slave shown");

	// slave index 0 has no owner in either order
	property p_unused_zero;
		@(posedge clk) disable iff (!arst_n) out_a[0] == 4'h0 && out_b[0] == 4'h0;
	endproperty
	a_unused_zero: assert property (p_unused_zero) else $error("index 0 written");

	sequence s_wr_slot0;
		wr_en && wr_in && mode == slot_order_sort && wr_off == '0;
	endsequence

	property p_wr_1a;
		@(posedge clk) disable iff (!arst_n)
		s_wr_slot0 |=> out_a[1] == $past(wr_data[3:0]) && out_a[0] == 4'h0;
	endproperty
	a_wr_1a: assert property (p_wr_1a) else $error("slave 1a write lost");

	sequence s_wr_pair;
		wr_en && wr_in && mode == address_paired_sort && wr_off != '0;
	endsequence

	property p_wr_pair;
		@(posedge clk) disable iff (!arst_n)
		s_wr_pair |=> out_a[$past(wr_off[4:0])] == $past(wr_data[3:0])
			&& out_b[$past(wr_off[4:0])] == $past(wr_data[7:4]);
	endproperty
	a_wr_pair: assert property (p_wr_pair) else $error("paired write lost");

	// a write outside the area must not alias onto byte 0 or 16
	property p_wr_outside;
		@(posedge clk) disable iff (!arst_n)
		(wr_en && !wr_in) |=> out_a[1] == $past(out_a[1]) && out_b[1] == $past(out_b[1]);
	endproperty
	a_wr_outside: assert property (p_wr_outside) else $error("outside write landed");
endmodule : io_image_mapper

// File: sim/ctrl_host.sv
// controller host model: byte reads and writes of the process image
// assumes the mapper answers a read one cycle after taking it
`timescale 1ns/1ps
module ctrl_host (
	input wire logic clk,
	output logic rd_en,
	output logic [15:0] rd_addr,
	input wire logic [7:0] rd_data,
	input wire logic rd_valid,
	output logic wr_en,
	output logic [15:0] wr_addr,
	output logic [7:0] wr_data
);
	initial begin
		rd_en = 1'h0;
		wr_en = 1'h0;
		rd_addr = 16'h0000;
		wr_addr = 16'h0000;
		wr_data = 8'h00;
	end
	// released lines show the inverse value
	task rd(input logic [15:0] a, output logic [7:0] d);
		@(posedge clk);
		rd_en <= 1'h1;
		rd_addr <= a;
		@(posedge clk);
		rd_en <= 1'h0;
		rd_addr <= ~a;
		#1;
		d = rd_valid ? rd_data : 8'hXX;
	endtask : rd
	task wr(input logic [15:0] a, input logic [7:0] d);
		@(posedge clk);
		wr_en <= 1'h1;
		wr_addr <= a;
		wr_data <= d;
		@(posedge clk);
		wr_en <= 1'h0;
		wr_addr <= ~a;
		wr_data <= ~d;
		#1;
	endtask : wr
endmodule : ctrl_host

// File: sim/asi_slave_io_image_mapper_bench.sv
// bench for the io image mapper: reads and writes in both sort orders
// assumes the host model drives the byte port
`timescale 1ns/1ps
module asi_slave_io_image_mapper_bench
	import io_image_pkg::*;
;
	logic clk, arst_n, area_short, rd_en, rd_valid, wr_en;
	sort_mode_t mode;
	logic [15:0] start_addr, rd_addr, wr_addr;
	logic [3:0] status_nib;
	logic [3:0] in_a [32], in_b [32], out_a [32], out_b [32];
	logic [31:0] cfg_a, cfg_b;
	logic [7:0] rd_data, wr_data, got;
	int n_errors, checked;
	io_image_mapper u_dut (.clk, .arst_n, .mode, .area_short, .start_addr, .status_nib,
		.in_a, .in_b, .cfg_a, .cfg_b, .rd_en, .rd_addr, .rd_data, .rd_valid, .wr_en,
		.wr_addr, .wr_data, .out_a, .out_b);
	ctrl_host u_host (.clk, .rd_en, .rd_addr, .rd_data, .rd_valid, .wr_en, .wr_addr,
		.wr_data);
	function automatic logic [3:0] na(int i);
		return cfg_a[i] ? in_a[i] : 4'h0;
	endfunction : na
	function automatic logic [3:0] nb(int i);
		return cfg_b[i] ? in_b[i] : 4'h0;
	endfunction : nb
	function automatic logic [7:0] exp_byte(int k);
		int j;
		j = k % 16;
		if (area_short && k > 15) return 8'h00;
		if (mode == address_paired_sort) return k == 0 ? {status_nib, 4'h0} : {nb(k), na(k)};
		if (mode != slot_order_sort) return k == 0 ? {status_nib, 4'h0} : 8'h00;
		if (k == 0) return {status_nib, na(1)};
		if (k < 16) return {na(2 * k), na(2 * k + 1)};
		return {j == 0 ? 4'h0 : nb(2 * j), nb(2 * j + 1)};
	endfunction : exp_byte
	task chk(input logic [7:0] g, input logic [7:0] e, input string s);
		checked++;
		if (g !== e) begin
			n_errors++;
			$display("CHECK FAILED %0t %s got %h exp %h", $time, s, g, e);
		end
	endtask : chk
	task setup(input sort_mode_t md, input logic sh, input logic [31:0] ca,
		input logic [31:0] cb, input logic [15:0] m);
		@(posedge clk);
		mode <= md;
		area_short <= sh;
		cfg_a <= ca;
		cfg_b <= cb;
		start_addr <= m;
		@(posedge clk);
	endtask : setup
	task sweep(input string s);
		for (int k = 0; k < 33; k++) begin
			u_host.rd(start_addr + 16'(k), got);
			chk(got, k < 32 ? exp_byte(k) : 8'h00, s);
		end
		$display("test %s done", s);
	endtask : sweep
	task t_slot;
		setup(slot_order_sort, 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0100);
		sweep("slot");
	endtask : t_slot
	task t_short;
		setup(slot_order_sort, 1'h1, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0100);
		sweep("short");
	endtask : t_short
	task t_unconf;
		setup(slot_order_sort, 1'h0, 32'h5A5A_A5A5, 32'hC3C3_3C3C, 16'h0040);
		sweep("unconf");
	endtask : t_unconf
	task t_paired;
		setup(address_paired_sort, 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'hFFF0);
		sweep("paired");
	endtask : t_paired
	task t_nomode;
		setup(sort_mode_t'(2'h0), 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0100);
		u_host.wr(16'h0105, 8'h77);
		chk({out_a[10], out_a[11]}, 8'h00, "nomode wr");
		sweep("nomode");
	endtask : t_nomode
	task t_reset;
		setup(slot_order_sort, 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0100);
		arst_n <= 1'h0;
		@(posedge clk);
		chk({out_a[1], out_b[9]}, 8'h00, "reset out");
		chk({7'h00, rd_valid}, 8'h00, "reset valid");
		arst_n <= 1'h1;
		u_host.rd(16'h0101, got);
		chk(got, exp_byte(1), "reset read");
		$display("test reset done");
	endtask : t_reset
	task t_wr_slot;
		setup(slot_order_sort, 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0100);
		u_host.wr(16'h0100, 8'hA5);
		chk({out_a[0], out_a[1]}, 8'h05, "wr0");
		u_host.wr(16'h0111, 8'h5A);
		chk({out_b[2], out_b[3]}, 8'h5A, "wr17");
		u_host.wr(16'h0110, 8'h3C);
		chk({out_b[0], out_b[1]}, 8'h0C, "wr16");
		u_host.wr(16'h0120, 8'hFF);
		chk({out_a[0], out_a[1]}, 8'h05, "wr32");
		$display("test wr_slot done");
	endtask : t_wr_slot
	task t_wr_paired;
		setup(address_paired_sort, 1'h0, 32'hFFFF_FFFF, 32'hFFFF_FFFF, 16'h0100);
		u_host.wr(16'h0109, 8'h96);
		chk({out_b[9], out_a[9]}, 8'h96, "pw9");
		u_host.wr(16'h0100, 8'hF7);
		chk({out_b[0], out_a[0]}, 8'h00, "pw0");
		$display("test wr_paired done");
	endtask : t_wr_paired
	task give_verdict;
		$display("checks %0d errors %0d", checked, n_errors);
		if (n_errors == 0 && checked > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask : give_verdict
	initial begin
		clk = 1'h0;
		forever #50 clk = ~clk;
	end
	initial begin
		#1000000;
		n_errors++;
		give_verdict;
	end
	initial begin
		arst_n = 1'h0;
		mode = slot_order_sort;
		area_short = 1'h0;
		start_addr = 16'h0100;
		status_nib = 4'hC;
		cfg_a = 32'hFFFF_FFFF;
		cfg_b = 32'hFFFF_FFFF;
		for (int i = 0; i < 32; i++) begin
			in_a[i] = 4'(i % 15 + 1);
			in_b[i] = 4'((i + 7) % 15 + 1);
		end
		repeat (20) @(posedge clk);
		arst_n <= 1'h1;
		t_slot;
		t_short;
		t_unconf;
		t_paired;
		t_wr_slot;
		t_wr_paired;
		t_nomode;
		t_reset;
		give_verdict;
	end
endmodule : asi_slave_io_image_mapper_bench
